/* File: include/sampling_readout_pkg.sv */
package sampling_readout_pkg;

    // =========================================================
    // sizes
    localparam int CHANNELS      = 8;
    localparam int GROUP_SIZE    = 4;
    localparam int RESULT_BITS   = 14;
    localparam int WORD_BITS     = 16;
    localparam int PAD_BITS      = 2;
    localparam int CHAN_IDX_BITS = 3;

    // =========================================================
    // conversion timing
    localparam int CLOCK_MHZ            = 50;
    localparam int CONV_TIME_MAX_NS     = 4000; // plain default
    // longest time rounds down
    localparam int CONV_CYCLES          = CONV_TIME_MAX_NS * CLOCK_MHZ / 1000;

    // =========================================================
    // interface select codes {primary, secondary}
    localparam logic [1:0] SEL_PARALLEL = 2'h0;
    localparam logic [1:0] SEL_SERIAL   = 2'h2;
    localparam logic [1:0] SEL_BYTE     = 2'h3;

    localparam logic [CHAN_IDX_BITS-1:0] CHAN_FIRST = 3'h0;
    localparam logic [CHAN_IDX_BITS-1:0] CHAN_LAST  = 3'h7;
    localparam logic [PAD_BITS-1:0]      PAD_ZERO   = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_WAIT    = 3'b010,
        ST_CONVERT = 3'b100
    } conv_state_e;

    // strobe set from the host
    typedef struct packed {
        logic chip_select_n;
        logic read_n;
    } strobes_s;

    // bus output quadruple
    typedef struct packed {
        logic [WORD_BITS-1:0] data;
        logic                 data_oe;
        logic                 flag;
        logic                 flag_oe;
    } bus_out_s;

endpackage

/* File: core/result_memory.sv */
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// result word store, registered read
module result_memory #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // clock
    input  wire logic             clock,
    // write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // write
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read
    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end

endmodule

`default_nettype wire

/* File: core/grouped_sampling_parallel_readout.sv */
// Overview of operation
// - first start edge holds channels 1-4
// - no conversion until second group sampled
// - second start edge holds channels 5-8
// - both sampled: convert, busy bounded by maximum
// - busy fall loads 14 bits plus zeros
// - read after reload completes returns new sample
// - read during busy returns previous sample
// - select pins choose parallel, byte, serial
// - parallel mode drives full sixteen-bit bus
// - tied strobes: first fall drives channel 1
// - flag high at first read fall
// - later read falls advance channel ascending
// - first read fall under chip select enables bus, read clocks data
// - flag low from second fall until deselect
// - frame end floats bus and flag
// - end of eight-word reload marks fresh results valid
// - lowest two bus bits driven low
`timescale 1ns/1ps
`default_nettype none
module grouped_sampling_parallel_readout #(
    parameter int CONV_CYCLES = sampling_readout_pkg::CONV_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // conversion control
    input  wire logic start_first_group,
    input  wire logic start_second_group,
    output logic      busy,
    output logic      hold_first_group,
    output logic      hold_second_group,
    // converter core sample results, one per channel
    input  wire logic [sampling_readout_pkg::CHANNELS*
                       sampling_readout_pkg::RESULT_BITS-1:0] conv_results,
    // interface select
    input  wire logic interface_select_primary,
    input  wire logic interface_select_secondary,
    output logic      parallel_mode,
    output logic      byte_mode,
    output logic      serial_mode,
    // host strobes
    input  wire sampling_readout_pkg::strobes_s strobes,
    // parallel bus
    output sampling_readout_pkg::bus_out_s     bus_out
);

    // =========================================================
    // reset release
    logic rst_meta;
    logic rst_n;
    // two-stage reset synchroniser
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // =========================================================
    // edge detection
    logic prev_start_a;
    logic prev_start_b;
    logic prev_cs_n;
    logic prev_rd_n;
    logic start_a_rise;
    logic start_b_rise;
    logic read_fall;
    logic frame_end;
    logic cs_active;
    // previous levels
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_start_a <= 1'b0;
            prev_start_b <= 1'b0;
            prev_cs_n    <= 1'b1;
            prev_rd_n    <= 1'b1;
        end else begin
            prev_start_a <= start_first_group;
            prev_start_b <= start_second_group;
            prev_cs_n    <= strobes.chip_select_n;
            prev_rd_n    <= strobes.read_n;
        end
    end
    // edge terms; tied strobes fall together so both cases match
    assign start_a_rise = start_first_group && !prev_start_a;
    assign start_b_rise = start_second_group && !prev_start_b;
    assign cs_active    = !strobes.chip_select_n;
    assign read_fall    = cs_active && !strobes.read_n && prev_rd_n;
    assign frame_end    = strobes.chip_select_n && !prev_cs_n;

    // =========================================================
    // interface select decode
    logic [1:0] sel;
    assign sel = {interface_select_primary, interface_select_secondary};
    always_comb begin
        parallel_mode = !interface_select_primary;
        byte_mode     = (sel == sampling_readout_pkg::SEL_BYTE);
        serial_mode   = (sel == sampling_readout_pkg::SEL_SERIAL);
    end

    // =========================================================
    // conversion sequencing
    sampling_readout_pkg::conv_state_e state;
    logic [31:0] conv_count;
    logic        conv_done;
    assign conv_done = (state == sampling_readout_pkg::ST_CONVERT)
                       && (conv_count == 32'(CONV_CYCLES - 1));
    // wait for both groups before converting
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state             <= sampling_readout_pkg::ST_IDLE;
            hold_first_group  <= 1'b0;
            hold_second_group <= 1'b0;
        end else begin
            case (state)
                sampling_readout_pkg::ST_IDLE,
                sampling_readout_pkg::ST_WAIT: begin
                    // group one hold at first start edge
                    hold_first_group  <= hold_first_group || start_a_rise;
                    // group two hold at second start edge
                    hold_second_group <= hold_second_group || start_b_rise;
                    if ((hold_first_group || start_a_rise) &&
                        (hold_second_group || start_b_rise)) begin
                        state <= sampling_readout_pkg::ST_CONVERT;
                    end else if (start_a_rise || start_b_rise) begin
                        state <= sampling_readout_pkg::ST_WAIT;
                    end
                end
                sampling_readout_pkg::ST_CONVERT: begin
                    if (conv_done) begin
                        state             <= sampling_readout_pkg::ST_IDLE;
                        hold_first_group  <= 1'b0;
                        hold_second_group <= 1'b0;
                    end
                end
                default: begin
                    state <= sampling_readout_pkg::ST_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conv_count <= 32'h0000_0000;
        end else if (state == sampling_readout_pkg::ST_CONVERT) begin
            conv_count <= conv_count + 32'h0000_0001;
        end else begin
            conv_count <= 32'h0000_0000;
        end
    end
    assign busy = (state == sampling_readout_pkg::ST_CONVERT);

    // =========================================================
    // result store; written channel by channel after conversion
    logic                                          load_active;
    logic [sampling_readout_pkg::CHAN_IDX_BITS-1:0] load_idx;
    logic                                          results_ready;
    // load 14-bit results on busy fall
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_active <= 1'b0;
            load_idx    <= sampling_readout_pkg::CHAN_FIRST;
        end else if (conv_done) begin
            load_active <= 1'b1;
            load_idx    <= sampling_readout_pkg::CHAN_FIRST;
        end else if (load_active) begin
            load_idx <= load_idx + 3'h1;
            if (load_idx == sampling_readout_pkg::CHAN_LAST) begin
                load_active <= 1'b0;
            end
        end
    end
    logic [sampling_readout_pkg::CHANNELS*
           sampling_readout_pkg::RESULT_BITS-1:0] captured;
    // snapshot taken exactly at busy fall
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            captured <= '0;
        end else if (conv_done) begin
            captured <= conv_results;
        end
    end
    // reads after reload see new words
    // reads held off until all words reloaded
    assign results_ready = !load_active;
    logic [sampling_readout_pkg::WORD_BITS-1:0] wr_word;
    assign wr_word = {captured[load_idx*sampling_readout_pkg::RESULT_BITS
                               +: sampling_readout_pkg::RESULT_BITS],
                      sampling_readout_pkg::PAD_ZERO};

    // =========================================================
    // read pointer
    logic [sampling_readout_pkg::CHAN_IDX_BITS-1:0] read_ptr;
    logic                                          first_read_done;
    // advance pointer on each parallel-mode read fall once results are ready
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_ptr        <= sampling_readout_pkg::CHAN_FIRST;
            first_read_done <= 1'b0;
        end else if (conv_done) begin
            read_ptr        <= sampling_readout_pkg::CHAN_FIRST;
            first_read_done <= 1'b0;
        end else if (read_fall && parallel_mode && results_ready) begin
            read_ptr        <= read_ptr + 3'h1;
            first_read_done <= 1'b1;
        end
    end
    logic [sampling_readout_pkg::WORD_BITS-1:0] rd_word;
    result_memory #(
        .WIDTH (sampling_readout_pkg::WORD_BITS),
        .DEPTH (sampling_readout_pkg::CHANNELS),
        .AW    (sampling_readout_pkg::CHAN_IDX_BITS)
    ) u_results (
        .clock   (clock),
        .wr_en   (load_active),
        .wr_addr (load_idx),
        .wr_data (wr_word),
        .rd_addr (read_ptr),
        .rd_data (rd_word)
    );

    // =========================================================
    // parallel bus drive
    // word of current channel on full bus
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_out.data <= '0;
        end else if (read_fall && parallel_mode && results_ready) begin
            bus_out.data <= {rd_word[sampling_readout_pkg::WORD_BITS-1:
                                     sampling_readout_pkg::PAD_BITS],
                             sampling_readout_pkg::PAD_ZERO};
        end
    end
    // read fall under chip select enables, read clocks data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_out.data_oe <= 1'b0;
            bus_out.flag_oe <= 1'b0;
        end else if (frame_end || !parallel_mode) begin
            // float bus and flag at frame end
            bus_out.data_oe <= 1'b0;
            bus_out.flag_oe <= 1'b0;
        end else if (read_fall && results_ready) begin
            bus_out.data_oe <= 1'b1;
            bus_out.flag_oe <= 1'b1;
        end
    end
    // flag high at first fall, low after
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_out.flag <= 1'b0;
        end else if (read_fall && parallel_mode && results_ready) begin
            bus_out.flag <= (read_ptr == sampling_readout_pkg::CHAN_FIRST)
                            && !first_read_done;
        end
    end

    // =========================================================
    // checks
    // busy never exceeds conversion time
    a_busy_limit: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(busy) |-> ##[1:CONV_CYCLES] !busy)
        else $error("busy exceeded conversion time");
    // no conversion with only group one held
    a_wait_second: assert property (@(posedge clock) disable iff (!rst_n)
        hold_first_group && !hold_second_group && !start_b_rise |=> !busy)
        else $error("conversion started before second group");
    a_low_bits: assert property (@(posedge clock) disable iff (!rst_n)
        bus_out.data[sampling_readout_pkg::PAD_BITS-1:0] == 2'h0)
        else $error("low bus bits not zero");
    a_frame_idle: assert property (@(posedge clock) disable iff (!rst_n)
        frame_end |=> !bus_out.data_oe && !bus_out.flag_oe)
        else $error("bus still driven after frame end");
    a_ptr_reset: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(busy) |-> read_ptr == sampling_readout_pkg::CHAN_FIRST)
        else $error("read pointer not reset");
    a_flag_low: assert property (@(posedge clock) disable iff (!rst_n)
        read_fall && parallel_mode && first_read_done |=> !bus_out.flag)
        else $error("first channel flag high after first read");
endmodule

`default_nettype wire

/* File: bench/host_reader.sv */
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// host side of the parallel read bus
module host_reader (
    // clock
    input  wire logic                            clock,
    // strobes to the device
    output var  sampling_readout_pkg::strobes_s strobes,
    // bus from the device
    input  wire sampling_readout_pkg::bus_out_s bus_out
);
    // idle with both strobes high
    initial strobes = 2'b11;

    // tied or separate strobes
    // one read, word taken two edges after the fall
    task automatic read_word(input logic tied,
                             output sampling_readout_pkg::bus_out_s got);
        strobes = 2'b00;
        repeat (2) @(posedge clock);
        #1 got = bus_out;
        strobes.read_n = 1'b1;
        if (tied) strobes.chip_select_n = 1'b1;
        @(posedge clock);
        #1;
    endtask

    task automatic end_frame();
        strobes = 2'b11;
        repeat (2) @(posedge clock);
        #1;
    endtask
endmodule

`default_nettype wire

/* File: bench/grouped_sampling_parallel_readout_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// self-checking bench
module grouped_sampling_parallel_readout_tb;
    localparam int CONV = 10;
    logic        clock;
    logic        nrst;
    logic        start_first_group;
    logic        start_second_group;
    logic        busy;
    logic        hold_first_group;
    logic        hold_second_group;
    logic [111:0] conv_results;
    logic        interface_select_primary;
    logic        interface_select_secondary;
    logic        parallel_mode;
    logic        byte_mode;
    logic        serial_mode;
    sampling_readout_pkg::strobes_s strobes;
    sampling_readout_pkg::bus_out_s bus_out;
    sampling_readout_pkg::bus_out_s b;
    logic [13:0] vals [8];
    logic [13:0] prev [8];
    int          miscompares;
    int          compares;
    int          cycles;

    grouped_sampling_parallel_readout #(.CONV_CYCLES(CONV)) dut (
        .clock                      (clock),
        .nrst                       (nrst),
        .start_first_group          (start_first_group),
        .start_second_group         (start_second_group),
        .busy                       (busy),
        .hold_first_group           (hold_first_group),
        .hold_second_group          (hold_second_group),
        .conv_results               (conv_results),
        .interface_select_primary   (interface_select_primary),
        .interface_select_secondary (interface_select_secondary),
        .parallel_mode              (parallel_mode),
        .byte_mode                  (byte_mode),
        .serial_mode                (serial_mode),
        .strobes                    (strobes),
        .bus_out                    (bus_out)
    );

    host_reader host (
        .clock   (clock),
        .strobes (strobes),
        .bus_out (bus_out)
    );

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // hang guard
    initial cycles = 0;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // =========================================================
    // helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // new core results, the last channel at full scale
    task automatic set_results(input logic [13:0] base);
        for (int i = 0; i < 8; i++) begin
            prev[i] = vals[i];
            vals[i] = (i == 7) ? 14'h3fff : base ^ 14'(i * 273);
            conv_results[i*14 +: 14] = vals[i];
        end
    endtask

    // bounded waits on busy
    task automatic wait_busy(input logic level, output int n);
        n = 0;
        while (busy !== level && n < 1000) begin
            @(posedge clock);
            #1 n++;
        end
    endtask

    task automatic read_frame(input logic tied);
        for (int i = 0; i < 8; i++) begin
            host.read_word(tied, b);
            check(b.data, {vals[i], 2'b00}, "word");
            check({15'h0000, b.flag}, {15'h0000, i == 0}, "flag");
            check({14'h0000, b.data_oe, b.flag_oe}, 16'h0003, "oe");
        end
    endtask

    task automatic frame_end();
        host.end_frame();
        check({14'h0000, bus_out.data_oe, bus_out.flag_oe}, 16'h0000,
              "float");
    endtask

    // =========================================================
    // scenarios
    task automatic t_split();
        int n;
        set_results(14'h2a50);
        start_first_group = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check({15'h0000, hold_first_group}, 16'h0001, "hold a");
        check({14'h0000, hold_second_group, busy}, 16'h0000, "wait");
        start_second_group = 1'b1;
        wait_busy(1'b1, n);
        check(16'(n), 16'h0001, "busy rise");
        check({15'h0000, hold_second_group}, 16'h0001, "hold b");
        start_first_group = 1'b0;
        start_second_group = 1'b0;
        wait_busy(1'b0, n);
        check(16'(n), 16'(CONV), "busy length");
        repeat (10) @(posedge clock);
        #1;
        read_frame(1'b1);
        frame_end();
        $display("test split done");
    endtask

    task automatic t_busy_read();
        int n;
        set_results(14'h1c63);
        start_first_group = 1'b1;
        start_second_group = 1'b1;
        wait_busy(1'b1, n);
        start_first_group = 1'b0;
        start_second_group = 1'b0;
        host.read_word(1'b0, b);
        check(b.data, {prev[0], 2'b00}, "old word");
        check({15'h0000, busy}, 16'h0001, "still busy");
        wait_busy(1'b0, n);
        repeat (10) @(posedge clock);
        #1;
        read_frame(1'b0);
        frame_end();
        $display("test busy read done");
    endtask

    task automatic t_modes();
        logic [1:0] sel;
        for (int k = 0; k < 3; k++) begin
            sel = (k == 0) ? sampling_readout_pkg::SEL_PARALLEL :
                  (k == 1) ? sampling_readout_pkg::SEL_SERIAL :
                             sampling_readout_pkg::SEL_BYTE;
            {interface_select_primary, interface_select_secondary} = sel;
            @(posedge clock);
            #1;
            check({13'h0000, parallel_mode, byte_mode, serial_mode},
                  {13'h0000, k == 0, k == 2, k == 1}, "mode");
        end
        host.read_word(1'b1, b);
        check({15'h0000, b.data_oe}, 16'h0000, "no bus");
        {interface_select_primary, interface_select_secondary} = 2'b00;
        $display("test modes done");
    endtask

    // =========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        start_first_group = 1'b0;
        start_second_group = 1'b0;
        interface_select_primary = 1'b0;
        interface_select_secondary = 1'b0;
        conv_results = '0;
        miscompares = 0;
        compares = 0;
        for (int i = 0; i < 8; i++) vals[i] = 14'h0000;
        repeat (4) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        t_split();
        t_busy_read();
        t_modes();
        tally_and_finish();
    end

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
endmodule

`default_nettype wire
